/* cam_pkg.sv */
// Package for the counter array mode control block.
// Assumes one system clock domain and an 8-bit register port driven by the core.
package cam_pkg;
    // Layout of the mode register, bit 7 down to bit 0.
    typedef struct packed {
        logic idle_suspend;
        logic watchdog_enable_bit;
        logic watchdog_lock_bit;
        logic unused_zero;
        logic [2:0] timebase_select;
        logic overflow_irq_enable;
    } cam_mode_t;

    // Timebase source codes.
    typedef enum logic [2:0] {
        CAM_TB_SYS_DIV12 = 3'h0,
        CAM_TB_SYS_DIV4 = 3'h1,
        CAM_TB_TIMER0 = 3'h2,
        CAM_TB_COUNT_IN = 3'h3,
        CAM_TB_SYS = 3'h4,
        CAM_TB_EXT_DIV8 = 3'h5,
        CAM_TB_RSVD6 = 3'h6,
        CAM_TB_RSVD7 = 3'h7
    } cam_tb_t;

    // Reset value: watchdog enabled, everything else clear.
    localparam logic [7:0] CAM_MODE_RESET = 8'h40;
    localparam int CAM_WATCHDOG_ENABLE_BIT_BIT = 6;

    // Divider figures.
    localparam logic [3:0] CAM_DIV12_LAST = 4'hB;
    localparam logic [1:0] CAM_DIV4_LAST = 2'h3;
    localparam logic [2:0] CAM_EXT_DIV_LAST = 3'h7;
    localparam logic [15:0] CAM_COUNT_MAX = 16'hFFFF;
    localparam int CAM_SYNC_CH = 2;
    localparam int CAM_CH_COUNT_IN = 0;
    localparam int CAM_CH_EXT_CLK = 1;
endpackage

/* cam_mode.sv */
// Mode control and main up-counter of the counter array.
// Assumes the core writes the mode register with a one-cycle strobe and that
// run, idle, timer 0 overflow and flag clear come from logic on the same clock.
// What this block does
// - Idle-suspend clear: counter keeps running while the core idles.
// - Idle-suspend set: all counting halts during core idle, resumes afterwards.
// - Watchdog enable bit makes module 2 the watchdog; clear means ordinary module.
// - Once the lock bit is set, clearing watchdog enable is ignored until reset.
// - Bit 4 reads zero and ignores writes.
// - Timebase field picks one of six count sources for the main counter.
// - Count input mode counts falling edges; source stays at or below clock/4.
// - Overflow interrupt enable masks the overflow flag onto the interrupt request.
// - Overflow flag sets on wrap from all ones to zero, held until cleared.
// - While watchdog enable is set, writes to other mode bits are blocked.
module cam_mode (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic mode_wr_i,
    input wire logic [7:0] mode_wdata_i,
    output logic [7:0] mode_rdata_o,
    input wire logic run_i,
    input wire logic cpu_idle_i,
    input wire logic timer0_ovf_i,
    input wire logic external_count_input_i,
    input wire logic ext_clk_i,
    input wire logic flag_clr_i,
    output logic [15:0] count_o,
    output logic counter_overflow_flag_o,
    output logic irq_o,
    output logic watchdog_on_o
);
    cam_pkg::cam_mode_t mode_ff;
    cam_pkg::cam_mode_t nxt_mode;
    cam_pkg::cam_mode_t wr_mode;
    logic [3:0] div12_ff;
    logic [1:0] div4_ff;
    logic [2:0] ext_div_ff;
    logic [15:0] count_ff;
    logic flag_ff;
    logic irq_ff;
    logic [cam_pkg::CAM_SYNC_CH-1:0] pin_in;
    logic [cam_pkg::CAM_SYNC_CH-1:0] stable_ff;
    logic [cam_pkg::CAM_SYNC_CH-1:0] fall_ev;
    logic [cam_pkg::CAM_SYNC_CH-1:0] rise_ev;
    logic active;
    logic tick;
    logic tick_en;
    logic wrap;
    logic nxt_flag;
    logic div12_tick;
    logic div4_tick;
    logic ext_tick;

    // Register write: reserved bit forced low, other bits frozen while the watchdog runs.
    assign wr_mode = cam_pkg::cam_mode_t'(mode_wdata_i & 8'hEF);
    always_comb begin
        nxt_mode = mode_ff;
        if (mode_wr_i) begin
            if (mode_ff.watchdog_enable_bit) begin
                // Only the enable may change, and only when unlocked.
                nxt_mode.watchdog_enable_bit = wr_mode.watchdog_enable_bit | mode_ff.watchdog_lock_bit;
            end else begin
                nxt_mode = wr_mode;
                nxt_mode.watchdog_lock_bit = wr_mode.watchdog_lock_bit | mode_ff.watchdog_lock_bit;
            end
        end
    end

    // Mode register; the lock bit only falls with system reset.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_ff <= cam_pkg::cam_mode_t'(cam_pkg::CAM_MODE_RESET);
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Pin synchronisers: three stages, a level counts once stages two and three agree.
    assign pin_in = {ext_clk_i, external_count_input_i};
    genvar g;
    generate
        for (g = 0; g < cam_pkg::CAM_SYNC_CH; g++) begin : g_sync
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic agree;
            assign agree = (s2_ff == s3_ff);
            assign fall_ev[g] = agree && stable_ff[g] && !s3_ff;
            assign rise_ev[g] = agree && !stable_ff[g] && s3_ff;
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    stable_ff[g] <= 1'b0;
                end else begin
                    s1_ff <= pin_in[g];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (agree) begin
                        stable_ff[g] <= s3_ff;
                    end
                end
            end
        end
    endgenerate

    // Idle suspension gates the dividers as well as the counter.
    assign active = run_i && !(cpu_idle_i && mode_ff.idle_suspend);
    assign div12_tick = (div12_ff == cam_pkg::CAM_DIV12_LAST);
    assign div4_tick = (div4_ff == cam_pkg::CAM_DIV4_LAST);
    assign ext_tick = rise_ev[cam_pkg::CAM_CH_EXT_CLK] && (ext_div_ff == cam_pkg::CAM_EXT_DIV_LAST);

    // Prescalers for the divided timebases.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div12_ff <= 4'h0;
            div4_ff <= 2'h0;
            ext_div_ff <= 3'h0;
        end else if (active) begin
            div12_ff <= div12_tick ? 4'h0 : div12_ff + 4'h1;
            div4_ff <= div4_ff + 2'h1;
            if (rise_ev[cam_pkg::CAM_CH_EXT_CLK]) begin
                ext_div_ff <= ext_div_ff + 3'h1;
            end
        end
    end

    // Timebase selection; reserved codes never tick.
    always_comb begin
        unique case (cam_pkg::cam_tb_t'(mode_ff.timebase_select))
            cam_pkg::CAM_TB_SYS_DIV12: tick = div12_tick;
            cam_pkg::CAM_TB_SYS_DIV4: tick = div4_tick;
            cam_pkg::CAM_TB_TIMER0: tick = timer0_ovf_i;
            cam_pkg::CAM_TB_COUNT_IN: tick = fall_ev[cam_pkg::CAM_CH_COUNT_IN];
            cam_pkg::CAM_TB_SYS: tick = 1'b1;
            cam_pkg::CAM_TB_EXT_DIV8: tick = ext_tick;
            cam_pkg::CAM_TB_RSVD6: tick = 1'b0;
            cam_pkg::CAM_TB_RSVD7: tick = 1'b0;
        endcase
    end

    assign tick_en = active && tick;
    assign wrap = tick_en && (count_ff == cam_pkg::CAM_COUNT_MAX);
    // Set wins over a clear in the same cycle.
    assign nxt_flag = wrap || (flag_ff && !flag_clr_i);

    // Main counter, overflow flag and masked request.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_ff <= 16'h0000;
            flag_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            if (tick_en) begin
                count_ff <= count_ff + 16'h0001;
            end
            flag_ff <= nxt_flag;
            irq_ff <= nxt_flag && nxt_mode.overflow_irq_enable;
        end
    end

    assign mode_rdata_o = mode_ff;
    assign watchdog_on_o = mode_ff.watchdog_enable_bit;
    assign count_o = count_ff;
    assign counter_overflow_flag_o = flag_ff;
    assign irq_o = irq_ff;

    // Checks kept beside the logic.
    chk_bit4_zero: assert property (@(posedge clk_i) disable iff (reset_i) mode_rdata_o[4] == 1'b0)
        else $error("Reserved mode bit reads one.");
    chk_lock_keeps_enable: assert property (@(posedge clk_i) disable iff (reset_i)
        mode_ff.watchdog_lock_bit && mode_ff.watchdog_enable_bit |=> watchdog_on_o)
        else $error("Locked watchdog enable was cleared.");
    chk_lock_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
        mode_ff.watchdog_lock_bit |=> mode_ff.watchdog_lock_bit)
        else $error("Watchdog lock fell without a reset.");
    chk_watchdog_enable_bit_freezes_bits: assert property (@(posedge clk_i) disable iff (reset_i)
        mode_ff.watchdog_enable_bit |=> ($past(mode_rdata_o) & 8'hBF) == (mode_rdata_o & 8'hBF))
        else $error("Mode bits changed while the watchdog ran.");
    chk_wdog_output: assert property (@(posedge clk_i) disable iff (reset_i)
        mode_wr_i && !mode_ff.watchdog_enable_bit |=> watchdog_on_o == $past(mode_wdata_i[cam_pkg::CAM_WATCHDOG_ENABLE_BIT_BIT]))
        else $error("Watchdog enable did not follow the write.");
    chk_reserved_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        mode_ff.timebase_select[2:1] == 2'h3 |=> $stable(count_o))
        else $error("Counter moved on a reserved timebase.");
    chk_idle_halt: assert property (@(posedge clk_i) disable iff (reset_i)
        cpu_idle_i && mode_ff.idle_suspend |=> $stable(count_o))
        else $error("Counter moved while suspended in idle.");

    // Each timebase source advances the counter by one in the cycle after its tick.
    chk_sysclk_counts: assert property (@(posedge clk_i) disable iff (reset_i)
        run_i && !cpu_idle_i && mode_ff.timebase_select == cam_pkg::CAM_TB_SYS |=>
        count_o == $past(count_o) + 16'h0001)
        else $error("System clock timebase did not advance the counter.");
    chk_div12_counts: assert property (@(posedge clk_i) disable iff (reset_i)
        active && div12_tick && mode_ff.timebase_select == cam_pkg::CAM_TB_SYS_DIV12 |=>
        count_o == $past(count_o) + 16'h0001)
        else $error("Divide-by-twelve timebase did not advance the counter.");
    chk_div4_counts: assert property (@(posedge clk_i) disable iff (reset_i)
        active && div4_tick && mode_ff.timebase_select == cam_pkg::CAM_TB_SYS_DIV4 |=>
        count_o == $past(count_o) + 16'h0001)
        else $error("Divide-by-four timebase did not advance the counter.");
    chk_timer0_counts: assert property (@(posedge clk_i) disable iff (reset_i)
        active && timer0_ovf_i && mode_ff.timebase_select == cam_pkg::CAM_TB_TIMER0 |=>
        count_o == $past(count_o) + 16'h0001)
        else $error("Timer 0 overflow did not advance the counter.");
    chk_count_in_counts: assert property (@(posedge clk_i) disable iff (reset_i)
        active && fall_ev[cam_pkg::CAM_CH_COUNT_IN] && mode_ff.timebase_select == cam_pkg::CAM_TB_COUNT_IN |=>
        count_o == $past(count_o) + 16'h0001)
        else $error("Count input falling edge did not advance the counter.");
    chk_ext_div_counts: assert property (@(posedge clk_i) disable iff (reset_i)
        active && ext_tick && mode_ff.timebase_select == cam_pkg::CAM_TB_EXT_DIV8 |=>
        count_o == $past(count_o) + 16'h0001)
        else $error("Divided external clock did not advance the counter.");

    // Overflow flag, its clear and the masked request.
    chk_overflow_sets: assert property (@(posedge clk_i) disable iff (reset_i)
        wrap |=> counter_overflow_flag_o && count_o == 16'h0000)
        else $error("Wrap did not set the overflow flag.");
    chk_flag_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
        counter_overflow_flag_o && !flag_clr_i |=> counter_overflow_flag_o)
        else $error("Overflow flag fell without a clear.");
    chk_flag_clears: assert property (@(posedge clk_i) disable iff (reset_i)
        flag_clr_i && !wrap |=> !counter_overflow_flag_o)
        else $error("Overflow flag survived a clear.");
    chk_irq_mask: assert property (@(posedge clk_i) disable iff (reset_i)
        irq_o == (flag_ff && mode_ff.overflow_irq_enable))
        else $error("Interrupt request disagrees with flag and mask.");

    // One synchronised pin edge gives one event.
    chk_edge_once: assert property (@(posedge clk_i) disable iff (reset_i)
        fall_ev[cam_pkg::CAM_CH_COUNT_IN] |=> !fall_ev[cam_pkg::CAM_CH_COUNT_IN])
        else $error("One falling edge gave two count pulses.");
    chk_rise_once: assert property (@(posedge clk_i) disable iff (reset_i)
        rise_ev[cam_pkg::CAM_CH_EXT_CLK] |=> !rise_ev[cam_pkg::CAM_CH_EXT_CLK])
        else $error("One external clock edge gave two events.");
endmodule

/* cam_core_model.sv */
// Behavioural model of the processor core that writes the mode register.
// Assumes one shared clock; the testbench calls the write tasks.
module cam_core_model (
    input wire logic clk_i,
    output logic mode_wr_o,
    output logic [7:0] mode_wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // The bus starts idle.
    initial begin
        mode_wr_o = 1'b0;
        mode_wdata_o = 8'h00;
    end
    // One-cycle strobe after an edge; when released, the data shows the inverse so stale values stand out.
    task automatic write(input logic [7:0] data);
        @(posedge clk_i);
        #1 mode_wr_o = 1'b1;
        mode_wdata_o = data;
        @(posedge clk_i);
        #1 mode_wr_o = 1'b0;
        mode_wdata_o = ~data;
    endtask
    // The watchdog enable is dropped before other settings change.
    task automatic set_mode(input logic [7:0] data);
        write(8'h00);
        write(data);
    endtask
endmodule

/* tb.sv */
// Self-checking testbench for the counter array mode control.
// Assumes the core model for register writes; pins are driven here.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, reset_i, run_i, cpu_idle_i, t0_ovf, external_count_input, ext_clk, flag_clr, wr, flag, irq, wd_on;
    logic [7:0] wdata, rdata;
    logic [15:0] count, c0;
    int n_fail, checks;
    cam_core_model u_core (.clk_i(clk_i), .mode_wr_o(wr), .mode_wdata_o(wdata));
    cam_mode dut (.clk_i(clk_i), .reset_i(reset_i), .mode_wr_i(wr), .mode_wdata_i(wdata), .mode_rdata_o(rdata),
        .run_i(run_i), .cpu_idle_i(cpu_idle_i), .timer0_ovf_i(t0_ovf), .external_count_input_i(external_count_input),
        .ext_clk_i(ext_clk), .flag_clr_i(flag_clr), .count_o(count), .counter_overflow_flag_o(flag),
        .irq_o(irq), .watchdog_on_o(wd_on));
    // The clock runs at 125 MHz.
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("n_fail=%0d checks=%0d", n_fail, checks);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Waits n edges and lands just after the last one.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic do_reset;
        reset_i = 1'b1;
        cyc(6);
        reset_i = 1'b0;
    endtask
    // Reset contents and the watchdog write lock.
    task automatic t_lock;
        check(rdata, 16'h0040);
        check(wd_on, 16'h0001);
        u_core.write(8'h4A); // Keeps the enable set, so only the other bits are tried.
        check(rdata, 16'h0040);
        u_core.write(8'h00);
        check({wd_on, rdata}, 16'h0000);
        u_core.write(8'hFF);
        check(rdata, 16'h00EF);
        u_core.write(8'h00);
        check(rdata, 16'h00EF);
        do_reset();
        check(rdata, 16'h0040);
        u_core.write(8'h00);
        check(rdata, 16'h0000);
    endtask
    // Every timebase code counted over a window whose length suits its divider.
    task automatic t_timebase;
        logic [15:0] exp [8] = '{16'h4, 16'hC, 16'h5, 16'h6, 16'h30, 16'h2, 16'h0, 16'h0};
        for (int c = 0; c < 8; c++) begin
            u_core.set_mode({4'h0, 3'(c), 1'b0});
            cyc(2);
            c0 = count;
            case (c)
                2: repeat (5) begin t0_ovf = 1'b1; cyc(1); t0_ovf = 1'b0; cyc(3); end
                3: repeat (6) begin external_count_input = 1'b0; cyc(4); external_count_input = 1'b1; cyc(4); end
                5: repeat (16) begin ext_clk = 1'b1; cyc(2); ext_clk = 1'b0; cyc(2); end
                default: cyc(48);
            endcase
            if (c == 2 || c == 3 || c == 5) cyc(8);
            check(count - c0, exp[c]);
        end
    endtask
    // Counting through core idle with and without suspend.
    task automatic t_idle;
        u_core.set_mode(8'h08);
        cpu_idle_i = 1'b1;
        c0 = count;
        cyc(20);
        check(count - c0, 16'h0014);
        u_core.set_mode(8'h88);
        c0 = count;
        cyc(20);
        check(count - c0, 16'h0000);
        cpu_idle_i = 1'b0;
        c0 = count;
        cyc(20);
        check(count - c0, 16'h0014);
        // With the run control off no source advances the counter.
        run_i = 1'b0;
        c0 = count;
        cyc(20);
        check(count - c0, 16'h0000);
        run_i = 1'b1;
        c0 = count;
        cyc(20);
        check(count - c0, 16'h0014);
    endtask
    // Wrap sets the sticky flag; the enable masks the request.
    task automatic t_ovf;
        u_core.set_mode(8'h09);
        for (int i = 0; i < 70000 && flag !== 1'b1; i++) cyc(1);
        if (flag !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        check(flag, 16'h0001);
        check(count, 16'h0000);
        check(irq, 16'h0001);
        u_core.write(8'h08);
        check({flag, irq}, 16'h0002);
        u_core.write(8'h09);
        check(irq, 16'h0001);
        flag_clr = 1'b1;
        cyc(1);
        flag_clr = 1'b0;
        check({flag, irq}, 16'h0000);
    endtask
    // Main sequence.
    initial begin
        run_i = 1'b1;
        external_count_input = 1'b1;
        reset_i = 1'b1;
        cpu_idle_i = 1'b0;
        t0_ovf = 1'b0;
        ext_clk = 1'b0;
        flag_clr = 1'b0;
        n_fail = 0;
        checks = 0;
        do_reset();
        t_lock();
        t_timebase();
        t_idle();
        t_ovf();
        end_sim();
    end
endmodule
